/* File: hdl/msr_pkg.sv */
package msr_pkg;

  // Link timing in microseconds and system clock rate
  localparam int CLK_MHZ = 125;
  localparam int LINK_PERIOD_MIN_US = 30;
  localparam int LINK_PERIOD_LONG_US = 50;
  localparam int DATA_SETUP_MIN_US = 5;
  localparam int DATA_SETUP_LONG_US = 25;
  // Frame timeout: two longest link periods without a falling edge
  localparam int FRAME_TIMEOUT_US = 2 * LINK_PERIOD_LONG_US;
  localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * CLK_MHZ;
  localparam int TIMEOUT_W = 16;

  // Frame layout
  localparam int DATA_BITS = 8;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;

  // Header field positions
  localparam int HDR_LEFT = 0;
  localparam int HDR_RIGHT = 1;
  localparam int HDR_ONE = 3;
  localparam int HDR_ZERO = 2;
  localparam int HDR_XSIGN = 4;
  localparam int HDR_YSIGN = 5;
  localparam int HDR_XOVF = 6;
  localparam int HDR_YOVF = 7;

  // Reset value of the synchroniser (idle link clock is high)
  localparam logic SYNC_RESET = 1'b1;

  // One decoded report
  typedef struct packed {
    logic left_button;
    logic right_button;
    logic horiz_move_overflow;
    logic vert_move_overflow;
    logic [8:0] horiz_move;
    logic [8:0] vert_move;
  } msr_report_t;

  // One received byte with its checks
  typedef struct packed {
    logic [7:0] data;
    logic error;
  } msr_byte_t;

endpackage

/* File: hdl/msr_sync.sv */
`timescale 1ns/1ps
module msr_sync
  import msr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  // Two flops; only the second one is read outside
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= SYNC_RESET;
      sync_ff <= SYNC_RESET;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* File: hdl/msr_frame_rx.sv */
`timescale 1ns/1ps
module msr_frame_rx
  import msr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fall,
  input wire logic data_s,
  input wire logic timeout,
  output logic byte_valid,
  output msr_byte_t byte_out
);

  typedef enum {MSR_IDLE, MSR_DATA, MSR_PARITY, MSR_STOP} msr_bit_state_t;

  msr_bit_state_t state_ff;
  logic [BIT_CNT_W-1:0] cnt_ff;
  logic [7:0] shift_ff;
  logic parity_ff;
  logic byte_valid_ff;
  msr_byte_t byte_ff;

  // Bit sequencing on each falling link edge
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= MSR_IDLE;
      cnt_ff <= '0;
      shift_ff <= 8'h00;
      parity_ff <= 1'b0;
    end else if (timeout) begin
      // Lost edges: resync at next start bit
      state_ff <= MSR_IDLE;
    end else if (fall) begin
      case (state_ff)
        MSR_IDLE: begin
          if (data_s == START_LEVEL) begin // R4
            state_ff <= MSR_DATA;
            cnt_ff <= '0;
            parity_ff <= 1'b0;
          end
        end
        MSR_DATA: begin
          shift_ff <= {data_s, shift_ff[7:1]}; // R3
          parity_ff <= parity_ff ^ data_s;
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == BIT_LAST_DATA) begin
            state_ff <= MSR_PARITY;
          end
        end
        MSR_PARITY: begin
          parity_ff <= parity_ff ^ data_s; // R2
          state_ff <= MSR_STOP;
        end
        MSR_STOP: begin
          state_ff <= MSR_IDLE;
        end
        default: begin
          state_ff <= MSR_IDLE;
        end
      endcase
    end
  end

  // Byte result; odd parity means xor of data and parity is one
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_valid_ff <= 1'b0;
      byte_ff <= '0;
    end else begin
      byte_valid_ff <= 1'b0;
      if (fall && !timeout && state_ff == MSR_STOP) begin
        byte_valid_ff <= 1'b1;
        byte_ff.data <= shift_ff;
        byte_ff.error <= (parity_ff != 1'b1) || (data_s != STOP_LEVEL); // R2 R4 R15
      end
    end
  end

  assign byte_valid = byte_valid_ff;
  assign byte_out = byte_ff;

endmodule

/* File: hdl/msr_receiver.sv */
`timescale 1ns/1ps
// Behaviour
// R1: The mouse keeps the link clock high when idle while data may rest at either level.
// R2: A frame is start, eight data bits, odd parity and stop, with parity making the ones count odd.
// R3: Data arrives least significant bit first, first bit landing in bit zero.
// R4: Start must be zero and stop must be one, otherwise the frame is malformed.
// R5: The link clock period lies between 30 and 50 microseconds and any such period is accepted.
// R6: Data changes 5 to 25 microseconds before each falling clock edge so it is stable there.
// R7: A report is header, X byte, Y byte, and the header has bit 3 set and bit 2 clear.
// R8: Header bits 0 and 1 give the left and right button, one meaning pressed.
// R9: Header bits 4 and 5 are the X and Y signs, one meaning negative.
// R10: Header bits 6 and 7 flag X and Y overflow.
// R11: The second byte holds the low eight bits of horizontal movement.
// R12: The third byte holds the low eight bits of vertical movement.
// R13: Right and up are positive, left and down are negative.
// R14: Data is sampled at falling link edges found after synchronising the link clock.
// R15: A parity or stop failure raises an error flag, drops the byte and waits for a new start.
// R16: Sign and byte join into nine-bit two's complement values, output with a one-cycle valid.
module msr_receiver
  import msr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_data,
  output msr_report_t report,
  output logic report_valid,
  output logic frame_error
);

  typedef enum {MSR_WAIT_HDR, MSR_WAIT_X, MSR_WAIT_Y} msr_pkt_state_t;

  logic clk_s;
  logic data_s;
  logic clk_prev_ff;
  logic fall;
  logic [TIMEOUT_W-1:0] idle_cnt_ff;
  logic timeout;
  logic byte_valid;
  msr_byte_t rx_byte;
  msr_pkt_state_t pkt_ff;
  logic [7:0] hdr_ff;
  logic [7:0] x_ff;
  msr_report_t report_ff;
  logic report_valid_ff;
  logic frame_error_ff;

  // Both pins pass two flops before use
  msr_sync u_sync_clk (
    .clk(clk),
    .rst(rst),
    .async_in(link_clk),
    .sync_out(clk_s)
  );

  msr_sync u_sync_data (
    .clk(clk),
    .rst(rst),
    .async_in(link_data),
    .sync_out(data_s)
  );

  // Falling edge of synchronised link clock; idle-high reset avoids a false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_prev_ff <= SYNC_RESET;
    end else begin
      clk_prev_ff <= clk_s;
    end
  end

  assign fall = clk_prev_ff & ~clk_s; // R14 R6

  // Watchdog between falling edges; any period up to 50 us stays well inside it
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_ff <= '0;
    end else if (fall) begin
      idle_cnt_ff <= '0;
    end else if (idle_cnt_ff != TIMEOUT_W'(FRAME_TIMEOUT_CYC)) begin
      idle_cnt_ff <= idle_cnt_ff + 16'h0001; // R5
    end
  end

  // Timeout only matters mid-frame or mid-report; idle clock high (R1) lets it saturate harmlessly
  assign timeout = (idle_cnt_ff == TIMEOUT_W'(FRAME_TIMEOUT_CYC) - 16'h0001); // R1

  msr_frame_rx u_frame (
    .clk(clk),
    .rst(rst),
    .fall(fall),
    .data_s(data_s),
    .timeout(timeout),
    .byte_valid(byte_valid),
    .byte_out(rx_byte)
  );

  // Header sanity bits; a byte out of step fails here and is skipped
  function automatic logic hdr_ok(input logic [7:0] b);
    hdr_ok = b[HDR_ONE] && !b[HDR_ZERO];
  endfunction

  // Report assembly; a bad byte restarts the report at the header
  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_ff <= MSR_WAIT_HDR;
      hdr_ff <= 8'h00;
      x_ff <= 8'h00;
    end else if (timeout) begin
      pkt_ff <= MSR_WAIT_HDR;
    end else if (byte_valid) begin
      if (rx_byte.error) begin
        pkt_ff <= MSR_WAIT_HDR; // R15
      end else begin
        case (pkt_ff)
          MSR_WAIT_HDR: begin
            if (hdr_ok(rx_byte.data)) begin // R7
              hdr_ff <= rx_byte.data;
              pkt_ff <= MSR_WAIT_X;
            end
          end
          MSR_WAIT_X: begin
            x_ff <= rx_byte.data; // R11
            pkt_ff <= MSR_WAIT_Y;
          end
          MSR_WAIT_Y: begin
            pkt_ff <= MSR_WAIT_HDR;
          end
          default: begin
            pkt_ff <= MSR_WAIT_HDR;
          end
        endcase
      end
    end
  end

  // Report output, held until the next report
  always_ff @(posedge clk) begin
    if (rst) begin
      report_ff <= '0;
      report_valid_ff <= 1'b0;
    end else begin
      report_valid_ff <= 1'b0;
      if (byte_valid && !rx_byte.error && !timeout && pkt_ff == MSR_WAIT_Y) begin
        report_valid_ff <= 1'b1; // R16
        report_ff.left_button <= hdr_ff[HDR_LEFT]; // R8
        report_ff.right_button <= hdr_ff[HDR_RIGHT]; // R8
        report_ff.horiz_move_overflow <= hdr_ff[HDR_XOVF]; // R10
        report_ff.vert_move_overflow <= hdr_ff[HDR_YOVF]; // R10
        // Sign on top makes right and up positive
        report_ff.horiz_move <= {hdr_ff[HDR_XSIGN], x_ff}; // R9 R13 R16
        report_ff.vert_move <= {hdr_ff[HDR_YSIGN], rx_byte.data}; // R9 R12 R13 R16
      end
    end
  end

  // Error pulse for a malformed byte
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_error_ff <= 1'b0;
    end else begin
      frame_error_ff <= byte_valid && rx_byte.error; // R15
    end
  end

  assign report = report_ff;
  assign report_valid = report_valid_ff;
  assign frame_error = frame_error_ff;

endmodule

/* File: sim/msr_receiver_props.sv */
`timescale 1ns/1ps
module msr_receiver_props
  import msr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_data,
  input wire msr_report_t report,
  input wire logic report_valid,
  input wire logic frame_error
);
  logic prev_ff;
  logic [3:0] age_ff;
  logic [5:0] falls_ff;
  logic stop_ff;
  wire logic fall = prev_ff && !link_clk;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last pin fall, saturating
  always_ff @(posedge clk) begin
    prev_ff <= rst | link_clk;
    if (rst) age_ff <= 4'hf;
    else if (fall) age_ff <= 4'h0;
    else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
  end
  // Pin falls since the last event; a junk header only adds, so compare with >=
  always_ff @(posedge clk) begin
    if (rst || report_valid || frame_error) falls_ff <= 6'h00;
    else if (fall && falls_ff != 6'h3f) falls_ff <= falls_ff + 6'h01;
  end
  // Pin data at the latest fall; before a report that is the stop bit
  always_ff @(posedge clk) begin
    if (rst) stop_ff <= 1'b1;
    else if (fall) stop_ff <= link_data;
  end
  property p_valid_pulse; report_valid |=> !report_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_err_pulse; frame_error |=> !frame_error; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error too long");
  property p_hold; $changed(report) |-> report_valid; endproperty
  a_hold: assert property (p_hold) else $error("report moved without valid");
  property p_valid_late; report_valid |-> age_ff <= 4'h8; endproperty
  a_valid_late: assert property (p_valid_late) else $error("valid far from a fall");
  property p_err_late; frame_error |-> age_ff <= 4'h8; endproperty
  a_err_late: assert property (p_err_late) else $error("error far from a fall");
  property p_valid_falls; report_valid |-> falls_ff >= 6'h21; endproperty
  a_valid_falls: assert property (p_valid_falls) else $error("report under three frames");
  property p_err_falls; frame_error |-> falls_ff >= 6'h0b; endproperty
  a_err_falls: assert property (p_err_falls) else $error("error under one frame");
  property p_valid_stop; report_valid |-> stop_ff; endproperty
  a_valid_stop: assert property (p_valid_stop) else $error("report after a low stop bit");
  property p_excl; report_valid |-> !frame_error; endproperty
  a_excl: assert property (p_excl) else $error("report and error together");
  property p_reset;
    disable iff (1'b0) rst |=> report == '0 && !report_valid && !frame_error;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared");
endmodule
bind msr_receiver msr_receiver_props u_props (.clk(clk), .rst(rst), .link_clk(link_clk), .link_data(link_data),
  .report(report), .report_valid(report_valid), .frame_error(frame_error));

/* File: sim/msr_mouse_model.sv */
`timescale 1ns/1ps
module msr_mouse_model (
  output logic link_clk,
  output logic link_data
);
  // Idle: clock high, data pulled high
  initial begin
    link_clk = 1'b1;
    link_data = 1'b1;
  end
  // One frame at an 80 ns link period; pb and sb break parity or stop on purpose
  // Steps are multiples of 8 ns, so pins and the caller stay off the sampling edge
  task automatic send(logic [7:0] b, logic pb, logic sb);
    logic [10:0] f;
    f = {~sb, ~(^b) ^ pb, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      #24 link_data = f[i];
      #16 link_clk = 1'b0;
      #40 link_clk = 1'b1;
    end
    #24 link_data = 1'b1;
  endtask
endmodule

/* File: sim/msr_receiver_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module msr_receiver_tb_top
  import msr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk;
  logic link_data;
  logic report_valid;
  logic frame_error;
  msr_report_t report;
  msr_report_t last;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int nv = 0;
  int ne = 0;
  int v;
  int e;
  logic [23:0] rows [4] = '{24'h09_0503, 24'h3a_fbf0, 24'hc8_ff00, 24'h0b_8001};
  msr_mouse_model mouse (.link_clk(link_clk), .link_data(link_data));
  msr_receiver DUT (.clk(clk), .rst(rst), .link_clk(link_clk), .link_data(link_data), .report(report),
    .report_valid(report_valid), .frame_error(frame_error));
  // Clock 125 MHz
  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard, about twice the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      mismatches++;
      conclude();
    end
  end
  // Strobes are counted at the falling edge, where they have settled
  always @(negedge clk) begin
    if (report_valid === 1'b1) begin
      nv++;
      last = report;
    end
    if (frame_error === 1'b1) ne++;
  end
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Expected report from header, X and Y bytes
  function automatic msr_report_t exp_rep(logic [23:0] r);
    return {r[16], r[17], r[22], r[23], r[20], r[15:8], r[21], r[7:0]};
  endfunction
  task automatic rep(logic [23:0] r);
    int w;
    w = ne;
    v = nv;
    mouse.send(r[23:16], 1'b0, 1'b0);
    mouse.send(r[15:8], 1'b0, 1'b0);
    mouse.send(r[7:0], 1'b0, 1'b0);
    repeat (20) @(negedge clk);
    `CHK("valid_count", v + 1, nv)
    `CHK("report", exp_rep(r), last)
    `CHK("rep_errors", w, ne)
  endtask
  // A stray byte, then a clean report that must still arrive intact
  task automatic junk(logic [7:0] b, logic pb, logic sb, int de);
    e = ne;
    mouse.send(b, pb, sb);
    rep(rows[0]);
    `CHK("error_count", e + de, ne)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK("reset_report", msr_report_t'(0), report)
    repeat (4) @(negedge clk);
    // Ordinary reports, back to back
    for (int i = 0; i < 4; i++) rep(rows[i]);
    // Bad parity mid-report, bad stop, malformed headers
    mouse.send(8'h09, 1'b0, 1'b0);
    junk(8'h05, 1'b1, 1'b0, 1);
    junk(8'h09, 1'b0, 1'b1, 1);
    junk(8'h01, 1'b0, 1'b0, 0);
    junk(8'h0c, 1'b0, 1'b0, 0);
    // Long silence after a header drops the half-built report
    mouse.send(8'h09, 1'b0, 1'b0);
    repeat (13000) @(negedge clk);
    junk(8'h05, 1'b0, 1'b0, 0);
    // Reset in mid-report clears the output
    mouse.send(8'h09, 1'b0, 1'b0);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("mid_reset_report", msr_report_t'(0), report)
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rep(rows[1]);
    conclude();
  end
endmodule
